// ---- hdl/timer_consts.svh ----
// Constants for the timer, PWM and capture unit
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define CNT_W 16
`define CNT_RST 16'h0000
`define CNT_ONE 16'h0001
`define NUM_CH 8
`define NUM_PAIR 4
`define NUM_TRIG 16
`define TRIG_SEL_W 4
`define FLT_W 4
`define PSC_W 7
`define SYNC_W 27
`define SYNC_PIN_LSB 0
`define SYNC_PHB 8
`define SYNC_PHA 9
`define SYNC_EXT 10
`define SYNC_TRIG_LSB 11
`define STAT_W 9
`define STAT_OVF 8
`define MS_OFF 2'b00
`define MS_COMPARE 2'b01
`define MS_PWM 2'b10
`define MS_PULSE 2'b11
`define ELS_NONE 2'b00
`define ELS_A 2'b01
`define ELS_B 2'b10
`define ELS_AB 2'b11
`endif

// ---- hdl/timer_pkg.sv ----
// Types shared by the timer, PWM and capture unit
package timer_pkg;
  // Counter clock source select
  typedef enum logic [1:0] {
    CLK_NONE,
    CLK_SYS,
    CLK_EXT,
    CLK_TRIG
  } clk_src_type;
  // Per-channel control bits
  typedef struct packed {
    logic mode_select_b;
    logic mode_select_a;
    logic edge_level_select_b;
    logic edge_level_select_a;
    logic active_high;
    logic trig_en;
    logic init_level;
  } chan_cfg_type;
  // Quadrature decoder setup
  typedef struct packed {
    logic enable;
    logic count_dir;
    logic pha_inv;
    logic phb_inv;
  } quad_cfg_type;
endpackage : timer_pkg

// ---- hdl/timer_pwm_capture_unit.sv ----
// Timer with compare, capture, PWM and quadrature decode
//
// Summary of operation
// - Compare match drives selected channel output action
// - Dual-edge capture on pairs zero to three
// - Filter value zero bypasses the input filter
// - Quadrature decode from phase A and B
// - Polarity bit sets input and output sense
// - Trigger captures, or gates output to initial
// - Trigger zero even channels, one odd
// - Per-channel and overflow interrupt enables
// - Value register holds capture or match value
// - Channel and overflow flags, mask clearable
// - Counter counts zero up to modulo
// - Live counter readable, zero to modulo
// - Clock source selected runs, none stops
// - Eight channels numbered zero to seven
// - Edge, center and combined pair PWM
// - Level select: high-true, low-true or off
// - Pause level drives PWM-mode output when stopped
// - With pause level, only disable stops output
// - Two mode and two level bits per channel
// - Trigger select among sixteen sources
// - Phase-A/B or count-direction, phases invertible
// - Clock from system, external pin or trigger
// - Prescaler divides by one to 128
// - Compare: none, toggle, clear, set, pulses
`timescale 1ns/10ps
`include "timer_consts.svh"
module timer_pwm_capture_unit
  import timer_pkg::*;
(
  input logic clock_i,
  input logic arst_n_i,
  input clk_src_type clk_sel_i,
  input logic [2:0] prescale_i,
  input logic [`TRIG_SEL_W-1:0] trig_sel_i,
  input logic [`CNT_W-1:0] modulo_i,
  input logic center_i,
  input quad_cfg_type quad_cfg_i,
  input chan_cfg_type [`NUM_CH-1:0] chan_cfg_i,
  input logic [`NUM_PAIR-1:0] combine_i,
  input logic [`NUM_PAIR-1:0] dual_edge_i,
  input logic [`NUM_PAIR-1:0][`FLT_W-1:0] filter_i,
  input logic pause_feature_i,
  input logic [`NUM_CH-1:0] pause_level_i,
  input logic [`NUM_CH-1:0] val_wr_i,
  input logic [`CNT_W-1:0] val_wdata_i,
  input logic [`NUM_CH-1:0] chan_ie_i,
  input logic ovf_ie_i,
  input logic [`STAT_W-1:0] status_clr_i,
  input logic [`NUM_TRIG-1:0] trig_in_i,
  input logic external_counter_clock_pin,
  input logic phase_a_i,
  input logic phase_b_i,
  input logic [`NUM_CH-1:0] chan_pin_i,
  output logic [`NUM_CH-1:0] chan_out_o,
  output logic [`NUM_CH-1:0][`CNT_W-1:0] chan_val_o,
  output logic [`CNT_W-1:0] count_o,
  output logic [`STAT_W-1:0] status_o,
  output logic irq_o
);
  logic [`SYNC_W-1:0] s1_r, s2_r, s3_r;
  logic [`NUM_TRIG-1:0] trig_s, trig_p;
  logic run, src_ev, tick, cnt_step, ovf;
  logic [`PSC_W-1:0] psc_r, psc_lim;
  logic qa, qb, qa_p, qb_p, q_step, q_up;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic down_r, down_nxt;
  logic [`CNT_W-1:0] cv_r [`NUM_CH];
  logic [`NUM_CH-1:0] ch_ev;
  logic [`NUM_CH-1:0] out_r;
  logic [`STAT_W-1:0] flag_r, flag_nxt;
  logic irq_r;
  // Two-stage synchronisers, third stage only for edge detection
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {trig_in_i, external_counter_clock_pin, phase_a_i,
               phase_b_i, chan_pin_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign trig_s = s2_r[`SYNC_TRIG_LSB +: `NUM_TRIG];
  assign trig_p = s3_r[`SYNC_TRIG_LSB +: `NUM_TRIG];
  assign run = (clk_sel_i != CLK_NONE);
  // Counter clock source
  // Pin clocks count their rising edges, so keep them below half rate
  always_comb begin
    unique case (clk_sel_i)
      CLK_NONE: src_ev = 1'b0;
      CLK_SYS: src_ev = 1'b1;
      CLK_EXT: src_ev = s2_r[`SYNC_EXT] & ~s3_r[`SYNC_EXT];
      CLK_TRIG: src_ev = trig_s[trig_sel_i] & ~trig_p[trig_sel_i];
    endcase
  end
  assign psc_lim = `PSC_W'((8'h01 << prescale_i) - 8'h01);
  assign tick = src_ev & (psc_r >= psc_lim); // Lowered ratio steps at once
  // Prescaler count restarts whenever the counter is stopped
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      psc_r <= '0;
    end else if (!run || tick) begin
      psc_r <= '0;
    end else if (src_ev) begin
      psc_r <= psc_r + `PSC_W'(1);
    end
  end
  assign qa = s2_r[`SYNC_PHA] ^ quad_cfg_i.pha_inv;
  assign qb = s2_r[`SYNC_PHB] ^ quad_cfg_i.phb_inv;
  assign qa_p = s3_r[`SYNC_PHA] ^ quad_cfg_i.pha_inv;
  assign qb_p = s3_r[`SYNC_PHB] ^ quad_cfg_i.phb_inv;
  // Quadrature step and direction
  // Phase mode counts every edge (x4); encoder steps skip the prescaler
  assign q_step = quad_cfg_i.count_dir ? (qa & ~qa_p) :
                  ((qa ^ qa_p) | (qb ^ qb_p));
  assign q_up = quad_cfg_i.count_dir ? qb : (qa ^ qb_p);
  assign cnt_step = run & (quad_cfg_i.enable ? q_step : tick);
  // Up, up-down or quadrature counting
  // A modulo of zero is not guarded in up-down mode.
  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    ovf = 1'b0;
    if (!center_i || quad_cfg_i.enable) begin
      down_nxt = 1'b0;
    end
    if (cnt_step) begin
      if (quad_cfg_i.enable) begin
        if (q_up) begin
          if (cnt_r >= modulo_i) begin
            cnt_nxt = `CNT_RST;
            ovf = 1'b1;
          end else begin
            cnt_nxt = cnt_r + `CNT_ONE;
          end
        end else if (cnt_r == `CNT_RST) begin
          cnt_nxt = modulo_i;
          ovf = 1'b1;
        end else begin
          cnt_nxt = cnt_r - `CNT_ONE;
        end
      end else if (center_i) begin
        if (!down_r) begin
          if (cnt_r >= modulo_i) begin
            down_nxt = 1'b1;
            cnt_nxt = cnt_r - `CNT_ONE;
            ovf = 1'b1;
          end else begin
            cnt_nxt = cnt_r + `CNT_ONE;
          end
        end else if (cnt_r == `CNT_RST) begin
          down_nxt = 1'b0;
          cnt_nxt = cnt_r + `CNT_ONE;
        end else begin
          cnt_nxt = cnt_r - `CNT_ONE;
        end
      end else if (cnt_r >= modulo_i) begin
        cnt_nxt = `CNT_RST;
        ovf = 1'b1;
      end else begin
        cnt_nxt = cnt_r + `CNT_ONE;
      end
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= `CNT_RST;
      down_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
    end
  end
  genvar i;
  generate
    for (i = 0; i < `NUM_CH; i++) begin : g_ch
      localparam int P = i / 2;
      localparam int EVN = i & 6;
      localparam int ODD = EVN + 1;
      chan_cfg_type cfg;
      logic [1:0] ms, els;
      logic in_pol, fin, flt_r, fin_p_r, rise, fall;
      logic [`FLT_W-1:0] fcnt_r;
      logic trg, trg_rise, is_in, cap_ev, match;
      logic pwm_hi, raw, off, oc_r, out_nxt;
      assign cfg = chan_cfg_i[i];
      assign ms = {cfg.mode_select_b, cfg.mode_select_a};
      assign els = {cfg.edge_level_select_b, cfg.edge_level_select_a};
      assign in_pol = (dual_edge_i[P] ? s2_r[EVN] : s2_r[i])
                      ^ ~cfg.active_high;
      assign fin = (filter_i[P] == '0) ? in_pol : flt_r;
      // Filter needs the input stable for one cycle more than the programmed count
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          flt_r <= 1'b0;
          fcnt_r <= '0;
          fin_p_r <= 1'b0;
        end else begin
          fin_p_r <= fin;
          if (filter_i[P] == '0 || in_pol == flt_r) begin
            flt_r <= in_pol;
            fcnt_r <= '0;
          end else if (fcnt_r >= filter_i[P]) begin
            flt_r <= in_pol;
            fcnt_r <= '0;
          end else begin
            fcnt_r <= fcnt_r + `FLT_W'(1);
          end
        end
      end
      assign rise = fin & ~fin_p_r;
      assign fall = ~fin & fin_p_r;
      assign trg = trig_s[i % 2];
      assign trg_rise = trig_s[i % 2] & ~trig_p[i % 2];
      assign is_in = (ms == `MS_OFF) && (els != `ELS_NONE);
      assign cap_ev = is_in & (cfg.trig_en ? trg_rise :
                      ((els[0] & rise) | (els[1] & fall)));
      assign match = cnt_step & (ms != `MS_OFF) & (cnt_r == cv_r[i]);
      assign ch_ev[i] = cap_ev | match;
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          cv_r[i] <= `CNT_RST;
        end else if (cap_ev) begin
          cv_r[i] <= cnt_r;
        end else if (val_wr_i[i]) begin
          cv_r[i] <= val_wdata_i;
        end
      end
      assign chan_val_o[i] = cv_r[i];
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          oc_r <= 1'b0;
        end else if (ms == `MS_COMPARE) begin
          if (match) begin
            unique case (els)
              `ELS_NONE: oc_r <= oc_r;
              `ELS_A: oc_r <= ~oc_r;
              `ELS_B: oc_r <= 1'b0;
              `ELS_AB: oc_r <= 1'b1;
            endcase
          end
        end else if (ms == `MS_PULSE && (els == `ELS_A || els == `ELS_B))
        begin
          // Pulse lasts one counter step, then returns to idle
          if (match) begin
            oc_r <= els[0];
          end else if (cnt_step) begin
            oc_r <= ~els[0];
          end
        end else begin
          oc_r <= cfg.init_level;
        end
      end
      assign pwm_hi = combine_i[P] ?
                      (cnt_r >= cv_r[EVN] && cnt_r < cv_r[ODD]) :
                      (cnt_r < cv_r[i]);
      always_comb begin
        off = 1'b0;
        raw = oc_r;
        if (ms == `MS_PWM) begin
          raw = els[0] ? ~pwm_hi : pwm_hi;
          off = (els == `ELS_NONE) && !pause_feature_i;
        end
      end
      // Output select, trigger gating, polarity and pause level
      always_comb begin
        if (ms == `MS_OFF || off) begin
          out_nxt = 1'b0;
        end else if (pause_feature_i && !run && ms == `MS_PWM) begin
          out_nxt = pause_level_i[i];
        end else if (cfg.trig_en && !trg) begin
          out_nxt = cfg.init_level;
        end else begin
          out_nxt = raw ^ ~cfg.active_high;
        end
      end
      // Registered channel output
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          out_r[i] <= 1'b0;
        end else begin
          out_r[i] <= out_nxt;
        end
      end
    end
  endgenerate
  assign flag_nxt = (flag_r & ~status_clr_i) | {ovf, ch_ev};
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flag_nxt & {ovf_ie_i, chan_ie_i});
    end
  end
  assign chan_out_o = out_r;
  assign count_o = cnt_r;
  assign status_o = flag_r;
  assign irq_o = irq_r;
endmodule : timer_pwm_capture_unit

// ---- bench/timer_unit_checker.sv ----
// Port checker for the timer, PWM and capture unit
`timescale 1ns/10ps
`include "timer_consts.svh"
module timer_unit_checker
  import timer_pkg::*;
(
  input logic clock_i,
  input logic arst_n_i,
  input clk_src_type clk_sel_i,
  input logic [2:0] prescale_i,
  input logic [`CNT_W-1:0] modulo_i,
  input logic center_i,
  input quad_cfg_type quad_cfg_i,
  input chan_cfg_type [`NUM_CH-1:0] chan_cfg_i,
  input logic [`NUM_CH-1:0] chan_ie_i,
  input logic ovf_ie_i,
  input logic [`STAT_W-1:0] status_clr_i,
  input logic [`NUM_CH-1:0] chan_out_o,
  input logic [`CNT_W-1:0] count_o,
  input logic [`STAT_W-1:0] status_o,
  input logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Plain up-counting on every system clock, no encoder in charge
  wire up_run = clk_sel_i == CLK_SYS && prescale_i == 3'h0 &&
    !center_i && !quad_cfg_i.enable;
  // Two settled cycles, so a fresh start or divider change is skipped
  sequence s_run;
    up_run [*2] ##0 $stable(modulo_i);
  endsequence
  sequence s_wrap;
    count_o == `CNT_RST && status_o[`STAT_OVF] ##1 status_o[`STAT_OVF];
  endsequence
  AST_STEP: assert property (s_run ##0 count_o < modulo_i
    |=> count_o == $past(count_o) + `CNT_ONE) else $error("no step");
  AST_WRAP: assert property (s_run ##0 count_o == modulo_i
    |=> s_wrap) else $error("no wrap");
  AST_STOP: assert property (clk_sel_i == CLK_NONE [*3]
    |=> $stable(count_o)) else $error("count moved");
  AST_RANGE: assert property ($stable(modulo_i) && count_o <= modulo_i
    |=> $changed(modulo_i) || count_o <= modulo_i) else $error("range");
  AST_IRQ: assert property (1'b1
    |=> irq_o == |(status_o & $past({ovf_ie_i, chan_ie_i})))
    else $error("irq wrong");
  AST_CLR: assert property (status_clr_i[`STAT_OVF] &&
    clk_sel_i == CLK_NONE && $past(clk_sel_i) == CLK_NONE
    |=> !status_o[`STAT_OVF]) else $error("flag kept");
  AST_HOLD: assert property (status_o[`STAT_OVF] &&
    !status_clr_i[`STAT_OVF] |=> status_o[`STAT_OVF])
    else $error("flag lost");
  AST_OFF: assert property (chan_cfg_i[0][6:3] == 4'h0 [*2]
    |=> !chan_out_o[0]) else $error("off channel drives");
endmodule : timer_unit_checker
bind timer_pwm_capture_unit timer_unit_checker timer_unit_checker_i (.*);

// ---- bench/quad_enc_model.sv ----
// Encoder phase source standing in for the shaft sensor
`timescale 1ns/10ps
module quad_enc_model (
  input logic clock_i,
  input logic arst_n_i,
  input logic up_i,
  input logic dn_i,
  output logic phase_a_o,
  output logic phase_b_o
);
  logic [1:0] pos_r;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pos_r <= 2'h0;
    end else if (up_i) begin
      pos_r <= pos_r + 2'h1;
    end else if (dn_i) begin
      pos_r <= pos_r - 2'h1;
    end
  end
  // Gray order, A leads B upward; one phase moves per step
  assign phase_a_o = pos_r[1] ^ pos_r[0];
  assign phase_b_o = pos_r[1];
endmodule : quad_enc_model

// ---- bench/tb_timer_pwm_capture_unit.sv ----
// Self-checking bench for the timer, PWM and capture unit
`timescale 1ns/10ps
`include "timer_consts.svh"
module tb_timer_pwm_capture_unit
  import timer_pkg::*;
;
  logic clock_i, arst_n_i, center_i, pause_feature_i, ovf_ie_i, irq_o;
  logic external_counter_clock_pin, phase_a_i, phase_b_i, up, dn;
  clk_src_type clk_sel_i;
  logic [2:0] prescale_i;
  logic [`TRIG_SEL_W-1:0] trig_sel_i;
  logic [`CNT_W-1:0] modulo_i, val_wdata_i, count_o;
  quad_cfg_type quad_cfg_i;
  chan_cfg_type [`NUM_CH-1:0] chan_cfg_i;
  logic [`NUM_PAIR-1:0] combine_i, dual_edge_i;
  logic [`NUM_PAIR-1:0][`FLT_W-1:0] filter_i;
  logic [`NUM_CH-1:0] pause_level_i, val_wr_i, chan_ie_i, chan_pin_i;
  logic [`NUM_CH-1:0] chan_out_o;
  logic [`NUM_CH-1:0][`CNT_W-1:0] chan_val_o;
  logic [`STAT_W-1:0] status_clr_i, status_o;
  logic [`NUM_TRIG-1:0] trig_in_i;
  int num_errors, n_tests, i, k, m, c, e;
  timer_pwm_capture_unit timer_pwm_capture_unit_i (.*);
  quad_enc_model quad_enc_model_i (.clock_i, .arst_n_i, .up_i(up),
    .dn_i(dn), .phase_a_o(phase_a_i), .phase_b_o(phase_b_i));
  // 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Inputs move 1 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [63:0] s, x);
    n_tests++;
    if (s !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic wr_val(input int ch, input logic [15:0] v);
    val_wdata_i = v;
    val_wr_i = 8'(1 << ch);
    tick(1);
    val_wr_i = '0;
    // Let an edge pass so back-to-back writes never retouch the strobe
    tick(1);
  endtask : wr_val
  function automatic chan_cfg_type cfg(input int ms, els, ah, te);
    return {ms[1:0], els[1:0], ah[0], te[0], 1'b0};
  endfunction : cfg
  // Encoder count after a signed step, wrapping over 0..top
  function automatic int wrap(input int x, top);
    return (x % (top + 1) + top + 1) % (top + 1);
  endfunction : wrap
  // Main sequence; unused pair features stay off
  initial begin
    {center_i, pause_feature_i, ovf_ie_i, up, dn, prescale_i} = '0;
    {external_counter_clock_pin, combine_i, dual_edge_i} = '0;
    {val_wr_i, val_wdata_i, status_clr_i, trig_in_i, chan_pin_i} = '0;
    {quad_cfg_i, chan_cfg_i, chan_ie_i, num_errors, n_tests} = '0;
    clk_sel_i = CLK_NONE;
    modulo_i = 16'h0001;
    arst_n_i = 1'b0;
    void'($urandom(18));
    {filter_i, pause_level_i, trig_sel_i} = 28'($urandom);
    tick(6);
    arst_n_i = 1'b1;
    tick(1);
    for (k = 0; k < 4; k++) begin
      m = (k == 0) ? 1 : 1 + $urandom % 12;
      // Period kept at two ticks or more
      modulo_i = m[15:0];
      ovf_ie_i = k[0];
      clk_sel_i = CLK_SYS;
      for (i = 0; i < 40 && count_o != m; i++) tick(1);
      for (i = 1; i <= 2 * m + 2; i++) begin
        tick(1);
        // The wait ends on the top value, so the first edge wraps to zero
        chk("cnt", count_o, (i - 1) % (m + 1));
      end
      chk("irq", {status_o[`STAT_OVF], irq_o}, {1'b1, k[0]});
      clk_sel_i = CLK_NONE;
      tick(3);
      status_clr_i[`STAT_OVF] = 1'b1;
      tick(1);
      status_clr_i = '0;
      chk("clr", {status_o[`STAT_OVF], irq_o}, 0);
    end
    modulo_i = 16'hffff;
    for (k = 0; k < 8; k++) begin
      prescale_i = k[2:0];
      clk_sel_i = CLK_SYS;
      for (i = 0; i < 2; i++) begin
        c = count_o;
        for (e = 0; e < 300 && count_o == c; e++) tick(1);
      end
      chk("div", e, 1 << k);
    end
    prescale_i = 3'h0;
    modulo_i = 16'h0009;
    $display("count test done");
    wr_val(1, 16'h0005);
    chk("cv", chan_val_o[1], 5);
    // Compare actions, then PWM duty over ten periods of ten counts
    for (k = 1; k < 4; k++) begin
      m = $urandom % 2;
      chan_cfg_i[1] = cfg(1, k, m, 0);
      tick(12);
      for (i = 0, e = 0; i < 100; i++) begin
        c = chan_out_o[1];
        tick(1);
        e += (chan_out_o[1] != c);
      end
      chk("oc", (k == 1) ? e : chan_out_o[1], (k == 1) ? 10 : (k == 3) == m);
      m = (k == 1) ? 0 : $urandom % 11;
      wr_val(2, m[15:0]);
      chan_cfg_i[2] = cfg(2, k, 1, 0);
      tick(4);
      for (i = 0, e = 0; i < 100; i++) begin
        tick(1);
        e += chan_out_o[2];
      end
      chk("pwm", e, 10 * ((k == 2) ? m : 10 - m));
    end
    chk("flag", status_o[1], 1);
    $display("output test done");
    modulo_i = 16'h00c8;
    chan_ie_i = 8'($urandom);
    for (k = 3; k < 8; k++) wr_val(k, 16'hffff);
    tick(5 + $urandom % 40);
    clk_sel_i = CLK_NONE;
    chan_cfg_i[7:3] = {cfg(0, 1, 1, 0), cfg(0, 1, 0, 0), cfg(0, 1, 1, 1),
      cfg(0, 1, 1, 1), cfg(0, 1, 1, 0)};
    chan_pin_i = 8'hc0;
    tick(40);
    status_clr_i = '1;
    tick(1);
    status_clr_i = '0;
    m = count_o;
    chan_pin_i = 8'h08;
    trig_in_i[0] = 1'b1;
    tick(40);
    chk("flags", status_o, 9'h058);
    chk("irq", irq_o, |(8'h58 & chan_ie_i));
    chk("cap", {chan_val_o[6], chan_val_o[4], chan_val_o[3]}, {3{m[15:0]}});
    trig_in_i[1] = 1'b1;
    tick(40);
    chk("odd", status_o[5], 1);
    $display("capture test done");
    modulo_i = 16'h03e8;
    clk_sel_i = CLK_SYS;
    for (k = 0; k < 4; k++) begin
      quad_cfg_i = (k == 3) ? 4'b1100 : (k == 2) ? 4'b1010 : 4'b1000;
      tick(8);
      c = count_o;
      m = 4 + $urandom % 10;
      e = 0;
      repeat (m) begin
        // Count-direction mode steps up on an A rise while B is high
        e += (k == 3 && !phase_a_i && phase_b_i);
        {up, dn} = k[0] ? 2'b01 : 2'b10;
        tick(1);
        {up, dn} = 2'b00;
        tick(6);
      end
      c += (k == 3) ? e : (k == 0) ? m : -m;
      chk("quad", count_o, wrap(c, 1000));
    end
    $display("quadrature test done");
    stop_test;
  end
  // Watchdog: the run needs well under 20000 cycles
  initial begin
    #80000;
    num_errors++;
    stop_test;
  end
endmodule : tb_timer_pwm_capture_unit
